// ===== core/tbf_delay_line.sv
// delay line: shifts a level by a fixed number of enable strobes
// assumes en is a one-cycle strobe in the aclk domain
`timescale 1ns/1ps
`default_nettype none
module tbf_delay_line #(
	parameter int DEPTH = 128
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic en,
	input wire logic din,
	output logic dout
);
	logic [DEPTH-1:0] shift_q;

	// line idles high, so it fills with ones
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shift_q <= '1;
		end else if (en) begin
			shift_q <= {shift_q[DEPTH-2:0], din};
		end
	end

	assign dout = shift_q[DEPTH-1];
endmodule
`default_nettype wire

// ===== core/tbf_framer.sv
// type b framer: receiver tuning, frame build on transmit, frame strip on receive
// assumes carrier_tick strobes once per carrier cycle, symbols arrive decoded
// Function
// - parity off: none sent, none checked, passed
// - manual corner 0: corner follows receive mode
// - corner codes 106/212/424/848 kHz
// - fast miller filter bit drives filter mode
// - output delay holds signal out 128/fc
// - wide pll bit widens recovery pll
// - sof required: stream without sof discarded
// - received sof stripped, never stored
// - eof required: missing eof is protocol error
// - received eof stripped, never stored
// - width bit picks longest or shortest sof/eof
// - width and adjust: 11etu-8, 2etu+8 phases
// - skip sof: frames sent without sof
// - skip eof: frames sent without eof
// - guard field adds 0 to 3 bits
// - reserved bits zero, no function
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module tbf_framer
	import tbf_pkg::*;
#(
	parameter int DELAY_FC = OUT_DELAY_FC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic carrier_tick,
	input wire logic [1:0] rx_rate,
	input wire tbf_tx_char_t tx_char,
	input wire logic tx_valid,
	output logic tx_ack,
	output logic signal_out_pin,
	input wire tbf_rx_sym_t rx_sym,
	input wire logic rx_sym_valid,
	output logic [8:0] rx_data,
	output logic rx_data_nine,
	output logic rx_data_valid,
	output logic [1:0] hp_corner,
	output logic fast_miller_filter,
	output logic wide_pll,
	output logic irq
);
	typedef enum {
		TX_IDLE,
		TX_SOF_LO,
		TX_SOF_HI,
		TX_START,
		TX_DATA,
		TX_PAR,
		TX_STOP,
		TX_GUARD,
		TX_EOF_LO
	} tbf_tx_state_t;

	// phase lengths in carrier cycles
	function automatic logic [CNT_W-1:0] low_len(input logic width, input logic adjust);
		logic [CNT_W-1:0] len;
		len = width ? (adjust ? FC_LO_ADJ : FC_LO_MAX) : FC_LO_MIN;
		return len;
	endfunction

	function automatic logic [CNT_W-1:0] high_len(input logic width, input logic adjust);
		logic [CNT_W-1:0] len;
		len = width ? (adjust ? FC_HI_ADJ : FC_HI_MAX) : FC_HI_MIN;
		return len;
	endfunction

	tbf_tuning_t tuning_q;
	tbf_typeb_t typeb_q;
	logic framing_adjust_q;
	logic [IRQ_W-1:0] irq_status_q, irq_enable_q;
	logic [7:0] aw_addr_q, ar_addr_q;
	logic [31:0] w_data_q;
	logic w_lane0_q, aw_have_q, w_have_q;
	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;

	// ---------------- register bus ----------------
	wire aw_hs = s_axi_awvalid && awready_q;
	wire w_hs = s_axi_wvalid && wready_q;
	wire ar_hs = s_axi_arvalid && arready_q;
	wire do_write = aw_have_q && w_have_q && !bvalid_q;
	wire wr_tuning = do_write && w_lane0_q && (aw_addr_q == ADDR_TUNING);
	wire wr_typeb = do_write && w_lane0_q && (aw_addr_q == ADDR_TYPEB);
	wire wr_ctrl = do_write && w_lane0_q && (aw_addr_q == ADDR_CTRL);
	wire wr_enable = do_write && w_lane0_q && (aw_addr_q == ADDR_IRQ_ENABLE);
	wire wr_clear = do_write && w_lane0_q && (aw_addr_q == ADDR_IRQ_CLEAR);
	wire aw_mapped = (aw_addr_q == ADDR_TUNING) || (aw_addr_q == ADDR_TYPEB) || (aw_addr_q == ADDR_CTRL) ||
		(aw_addr_q == ADDR_IRQ_STATUS) || (aw_addr_q == ADDR_IRQ_ENABLE) || (aw_addr_q == ADDR_IRQ_CLEAR) ||
		(aw_addr_q == ADDR_LINE_STATUS);
	wire [IRQ_W-1:0] clear_bits = wr_clear ? w_data_q[IRQ_W-1:0] : '0;
	logic tx_busy, rx_in_frame_q;
	wire [7:0] rd_line = {6'h00, rx_in_frame_q, tx_busy};
	wire [7:0] ra = s_axi_araddr;
	wire rd_mapped = (ra == ADDR_TUNING) || (ra == ADDR_TYPEB) || (ra == ADDR_CTRL) || (ra == ADDR_IRQ_STATUS) ||
		(ra == ADDR_IRQ_ENABLE) || (ra == ADDR_IRQ_CLEAR) || (ra == ADDR_LINE_STATUS);
	wire [31:0] rd_value = (ra == ADDR_TUNING) ? {24'h000000, tuning_q} :
		(ra == ADDR_TYPEB) ? {24'h000000, typeb_q} :
		(ra == ADDR_CTRL) ? {31'h00000000, framing_adjust_q} :
		(ra == ADDR_IRQ_STATUS) ? {27'h0000000, irq_status_q} :
		(ra == ADDR_IRQ_ENABLE) ? {27'h0000000, irq_enable_q} :
		(ra == ADDR_LINE_STATUS) ? {24'h000000, rd_line} : 32'h00000000;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h00000000;
			w_lane0_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else begin
			awready_q <= !aw_have_q && !aw_hs && !do_write;
			wready_q <= !w_have_q && !w_hs && !do_write;
			if (aw_hs) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (w_hs) begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_lane0_q <= s_axi_wstrb[0];
			end
			if (do_write) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= aw_mapped ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= RESP_OKAY;
		end else begin
			arready_q <= !rvalid_q && !ar_hs;
			if (ar_hs) begin
				rvalid_q <= 1'b1;
				rdata_q <= rd_value;
				rresp_q <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
			end else if (rvalid_q && s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// configuration registers; reserved bits never stored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tuning_q <= RESET_TUNING;
			typeb_q <= RESET_TYPEB;
			framing_adjust_q <= 1'b0;
			irq_enable_q <= '0;
		end else begin
			if (wr_tuning) begin
				tuning_q <= w_data_q[7:0] & MASK_TUNING;
			end
			if (wr_typeb) begin
				typeb_q <= w_data_q[7:0] & MASK_TYPEB;
			end
			if (wr_ctrl) begin
				framing_adjust_q <= w_data_q[0];
			end
			if (wr_enable) begin
				irq_enable_q <= w_data_q[IRQ_W-1:0];
			end
		end
	end

	// ---------------- receiver tuning outputs ----------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hp_corner <= 2'h0;
			fast_miller_filter <= 1'b0;
			wide_pll <= 1'b0;
		end else begin
			hp_corner <= tuning_q.manual_corner ? tuning_q.corner_select : rx_rate;
			fast_miller_filter <= tuning_q.fast_miller_filter;
			wide_pll <= tuning_q.wide_pll;
		end
	end

	// ---------------- transmitter ----------------
	tbf_tx_state_t tx_state_q;
	logic [CNT_W-1:0] tx_cnt_q;
	logic [7:0] tx_shift_q;
	logic [2:0] tx_bit_q;
	logic tx_par_q, tx_last_q, tx_ack_q, tx_done_ev;
	wire phase_end = carrier_tick && (tx_cnt_q == '0);
	wire adj = framing_adjust_q;
	wire [CNT_W-1:0] lo_len_m1 = low_len(typeb_q.framing_width, adj) - CNT_W'(1);
	wire [CNT_W-1:0] hi_len_m1 = high_len(typeb_q.framing_width, adj) - CNT_W'(1);
	wire [CNT_W-1:0] etu_m1 = FC_ETU - CNT_W'(1);
	wire [CNT_W-1:0] guard_len = CNT_W'(typeb_q.guard_time) * FC_ETU;
	wire stop_next_char = !tx_last_q && (typeb_q.guard_time == 2'h0) && tx_valid;
	assign tx_busy = (tx_state_q != TX_IDLE);
	wire tx_line = (tx_state_q == TX_SOF_LO || tx_state_q == TX_START || tx_state_q == TX_EOF_LO) ? 1'b0 :
		(tx_state_q == TX_DATA) ? tx_shift_q[0] :
		(tx_state_q == TX_PAR) ? tx_par_q : 1'b1;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_state_q <= TX_IDLE;
			tx_cnt_q <= '0;
			tx_shift_q <= 8'h00;
			tx_bit_q <= 3'h0;
			tx_par_q <= 1'b0;
			tx_last_q <= 1'b0;
			tx_ack_q <= 1'b0;
			tx_done_ev <= 1'b0;
		end else begin
			tx_ack_q <= 1'b0;
			tx_done_ev <= 1'b0;
			if (carrier_tick && tx_cnt_q != '0) begin
				tx_cnt_q <= tx_cnt_q - CNT_W'(1);
			end
			case (tx_state_q)
				TX_IDLE: begin
					if (tx_valid && carrier_tick) begin
						tx_shift_q <= tx_char.data;
						tx_par_q <= ~^tx_char.data;
						tx_last_q <= tx_char.last;
						tx_ack_q <= 1'b1;
						tx_bit_q <= 3'h0;
						if (typeb_q.skip_transmit_sof) begin
							tx_state_q <= TX_START;
							tx_cnt_q <= etu_m1;
						end else begin
							tx_state_q <= TX_SOF_LO;
							tx_cnt_q <= lo_len_m1;
						end
					end
				end
				TX_SOF_LO: begin
					if (phase_end) begin
						tx_state_q <= TX_SOF_HI;
						tx_cnt_q <= hi_len_m1;
					end
				end
				TX_SOF_HI: begin
					if (phase_end) begin
						tx_state_q <= TX_START;
						tx_cnt_q <= etu_m1;
					end
				end
				TX_START: begin
					if (phase_end) begin
						tx_state_q <= TX_DATA;
						tx_cnt_q <= etu_m1;
					end
				end
				TX_DATA: begin
					if (phase_end) begin
						tx_shift_q <= {1'b0, tx_shift_q[7:1]};
						tx_bit_q <= tx_bit_q + 3'h1;
						tx_cnt_q <= etu_m1;
						if (tx_bit_q == 3'h7) begin
							tx_state_q <= tuning_q.parity_off ? TX_STOP : TX_PAR;
						end
					end
				end
				TX_PAR: begin
					if (phase_end) begin
						tx_state_q <= TX_STOP;
						tx_cnt_q <= etu_m1;
					end
				end
				TX_STOP: begin
					if (phase_end) begin
						if (tx_last_q) begin
							if (typeb_q.skip_transmit_eof) begin
								tx_state_q <= TX_IDLE;
								tx_done_ev <= 1'b1;
							end else begin
								tx_state_q <= TX_EOF_LO;
								tx_cnt_q <= lo_len_m1;
							end
						end else if (stop_next_char) begin
							tx_shift_q <= tx_char.data;
							tx_par_q <= ~^tx_char.data;
							tx_last_q <= tx_char.last;
							tx_ack_q <= 1'b1;
							tx_bit_q <= 3'h0;
							tx_state_q <= TX_START;
							tx_cnt_q <= etu_m1;
						end else begin
							tx_state_q <= TX_GUARD;
							tx_cnt_q <= (guard_len == '0) ? '0 : guard_len - CNT_W'(1);
						end
					end
				end
				TX_GUARD: begin
					if (phase_end && tx_valid) begin
						tx_shift_q <= tx_char.data;
						tx_par_q <= ~^tx_char.data;
						tx_last_q <= tx_char.last;
						tx_ack_q <= 1'b1;
						tx_bit_q <= 3'h0;
						tx_state_q <= TX_START;
						tx_cnt_q <= etu_m1;
					end
				end
				TX_EOF_LO: begin
					if (phase_end) begin
						tx_state_q <= TX_IDLE;
						tx_done_ev <= 1'b1;
					end
				end
				default: begin
					tx_state_q <= TX_IDLE;
				end
			endcase
		end
	end

	logic line_delayed;
	tbf_delay_line #(
		.DEPTH(DELAY_FC)
	) u_delay (
		.aclk(aclk),
		.aresetn(aresetn),
		.en(carrier_tick),
		.din(tx_line),
		.dout(line_delayed)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			signal_out_pin <= 1'b1;
		end else begin
			signal_out_pin <= tuning_q.output_delay ? line_delayed : tx_line;
		end
	end

	// ---------------- receive stream ----------------
	logic rx_discard_q, rx_done_ev, rx_proto_ev, rx_par_ev, rx_disc_ev;
	wire sym_sof = rx_sym_valid && (rx_sym.kind == SYM_SOF);
	wire sym_char = rx_sym_valid && (rx_sym.kind == SYM_CHAR);
	wire sym_eof = rx_sym_valid && (rx_sym.kind == SYM_EOF);
	wire sym_end = rx_sym_valid && (rx_sym.kind == SYM_END);
	wire no_sof_start = sym_char && !rx_in_frame_q && typeb_q.sof_required;
	wire char_keep = sym_char && !rx_discard_q && !no_sof_start;
	wire parity_bad = !tuning_q.parity_off && !(^rx_sym.data);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_in_frame_q <= 1'b0;
			rx_discard_q <= 1'b0;
			rx_data <= 9'h000;
			rx_data_nine <= 1'b0;
			rx_data_valid <= 1'b0;
			rx_done_ev <= 1'b0;
			rx_proto_ev <= 1'b0;
			rx_par_ev <= 1'b0;
			rx_disc_ev <= 1'b0;
		end else begin
			rx_data_valid <= char_keep;
			rx_done_ev <= 1'b0;
			rx_proto_ev <= 1'b0;
			rx_par_ev <= char_keep && parity_bad;
			rx_disc_ev <= no_sof_start && !rx_discard_q;
			if (char_keep) begin
				rx_data <= tuning_q.parity_off ? rx_sym.data : {1'b0, rx_sym.data[7:0]};
				rx_data_nine <= tuning_q.parity_off;
			end
			if (sym_sof) begin
				rx_in_frame_q <= 1'b1;
				rx_discard_q <= 1'b0;
			end
			if (sym_char) begin
				rx_in_frame_q <= 1'b1;
				if (no_sof_start) begin
					rx_discard_q <= 1'b1;
				end
			end
			if (sym_eof) begin
				rx_in_frame_q <= 1'b0;
				rx_discard_q <= 1'b0;
				rx_done_ev <= rx_in_frame_q && !rx_discard_q;
			end
			if (sym_end) begin
				rx_in_frame_q <= 1'b0;
				rx_discard_q <= 1'b0;
				rx_proto_ev <= rx_in_frame_q && !rx_discard_q && typeb_q.eof_required;
				rx_done_ev <= rx_in_frame_q && !rx_discard_q && !typeb_q.eof_required;
			end
		end
	end

	// ---------------- interrupts ----------------
	wire [IRQ_W-1:0] events = {rx_disc_ev, tx_done_ev, rx_par_ev, rx_proto_ev, rx_done_ev};
	wire [IRQ_W-1:0] status_d = (irq_status_q & ~clear_bits) | events;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_status_q <= '0;
			tx_ack <= 1'b0;
			irq <= 1'b0;
		end else begin
			irq_status_q <= status_d;
			tx_ack <= tx_ack_q;
			irq <= |(status_d & irq_enable_q);
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
endmodule
`default_nettype wire

// ===== core/tbf_pkg.sv
// package: register map, field layouts, framing times and shared types
// assumes byte-wide control registers on a 32-bit register bus
package tbf_pkg;
	// register indices and byte addresses
	localparam logic [7:0] IDX_TUNING = 8'h1d;
	localparam logic [7:0] IDX_TYPEB = 8'h1e;
	localparam logic [7:0] ADDR_TUNING = 8'h74;
	localparam logic [7:0] ADDR_TYPEB = 8'h78;
	localparam logic [7:0] ADDR_CTRL = 8'h7c;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h80;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h84;
	localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h88;
	localparam logic [7:0] ADDR_LINE_STATUS = 8'h8c;
	localparam logic [7:0] RESET_TUNING = 8'h00;
	localparam logic [7:0] RESET_TYPEB = 8'h00;
	// writable bits; reserved bits stay zero
	localparam logic [7:0] MASK_TUNING = 8'h7f;
	localparam logic [7:0] MASK_TYPEB = 8'hdf;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// event bits
	localparam int IRQ_W = 5;
	localparam int EV_RX_DONE = 0;
	localparam int EV_PROTO_ERR = 1;
	localparam int EV_PARITY_ERR = 2;
	localparam int EV_TX_DONE = 3;
	localparam int EV_DISCARD = 4;
	// framing times in etu and carrier cycles
	localparam int ETU_FC = 128;
	localparam int SOF_LO_MIN_ETU = 10;
	localparam int SOF_LO_MAX_ETU = 11;
	localparam int SOF_HI_MIN_ETU = 2;
	localparam int SOF_HI_MAX_ETU = 3;
	localparam int ADJUST_FC = 8;
	localparam int OUT_DELAY_FC = 128;
	localparam int CNT_W = 13;
	localparam logic [CNT_W-1:0] FC_ETU = CNT_W'(ETU_FC);
	localparam logic [CNT_W-1:0] FC_LO_MIN = CNT_W'(SOF_LO_MIN_ETU * ETU_FC);
	localparam logic [CNT_W-1:0] FC_LO_MAX = CNT_W'(SOF_LO_MAX_ETU * ETU_FC);
	localparam logic [CNT_W-1:0] FC_LO_ADJ = CNT_W'(SOF_LO_MAX_ETU * ETU_FC - ADJUST_FC);
	localparam logic [CNT_W-1:0] FC_HI_MIN = CNT_W'(SOF_HI_MIN_ETU * ETU_FC);
	localparam logic [CNT_W-1:0] FC_HI_MAX = CNT_W'(SOF_HI_MAX_ETU * ETU_FC);
	localparam logic [CNT_W-1:0] FC_HI_ADJ = CNT_W'(SOF_HI_MIN_ETU * ETU_FC + ADJUST_FC);

	typedef struct packed {
		logic reserved;
		logic fast_miller_filter;
		logic output_delay;
		logic parity_off;
		logic wide_pll;
		logic manual_corner;
		logic [1:0] corner_select;
	} tbf_tuning_t;

	typedef struct packed {
		logic sof_required;
		logic eof_required;
		logic reserved;
		logic framing_width;
		logic skip_transmit_sof;
		logic skip_transmit_eof;
		logic [1:0] guard_time;
	} tbf_typeb_t;

	typedef enum logic [1:0] {
		SYM_SOF,
		SYM_CHAR,
		SYM_EOF,
		SYM_END
	} tbf_sym_kind_t;

	typedef struct packed {
		tbf_sym_kind_t kind;
		logic [8:0] data;
	} tbf_rx_sym_t;

	typedef struct packed {
		logic [7:0] data;
		logic last;
	} tbf_tx_char_t;
endpackage

// ===== dv/tbf_framer_monitor.sv
// checker: bus answer timing, receive strip and transmit ack relations
// assumes bound into tbf_framer, one clock domain
`timescale 1ns/1ps
`default_nettype none
module tbf_monitor
	import tbf_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic tx_valid,
	input wire logic tx_ack,
	input wire tbf_rx_sym_t rx_sym,
	input wire logic rx_sym_valid,
	input wire logic [8:0] rx_data,
	input wire logic rx_data_nine,
	input wire logic rx_data_valid
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence sym_seen(tbf_sym_kind_t k);
		rx_sym_valid && rx_sym.kind == k;
	endsequence
	write_resp_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
		else $error("write response not on time");
	read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response not on time");
	resp_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	sof_strip_a: assert property (rx_data_valid |-> $past(rx_sym_valid) && $past(rx_sym.kind) == SYM_CHAR)
		else $error("start of frame delivered");
	eof_strip_a: assert property (sym_seen(SYM_EOF) |=> !rx_data_valid)
		else $error("end of frame delivered");
	nine_pass_a: assert property (sym_seen(SYM_CHAR) ##1 rx_data_valid && rx_data_nine |-> rx_data == $past(rx_sym.data))
		else $error("passed parity bit lost");
	ack_pulse_a: assert property (tx_ack |=> !tx_ack)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property (tx_ack |-> $past(tx_valid, 2))
		else $error("ack without offered char");
endmodule
`default_nettype wire

// ===== dv/tbf_peer.sv
// far-side model: sends decoded receive symbols, records the transmit line
// assumes carrier_tick pulses once per carrier cycle
`timescale 1ns/1ps
`default_nettype none
module tbf_peer
	import tbf_pkg::*;
(
	input wire logic aclk,
	input wire logic carrier_tick,
	input wire logic signal_out_pin,
	input wire logic rec,
	output var tbf_rx_sym_t rx_sym,
	output logic rx_sym_valid
);
	int runs[$];
	logic lvl_q;
	initial begin
		rx_sym = '0;
		rx_sym_valid = 1'b0;
	end
	// run lengths of the line, one sample per carrier cycle
	always @(posedge aclk) begin
		if (rec && carrier_tick) begin
			if (runs.size() == 0 || signal_out_pin !== lvl_q) begin
				runs.push_back(1);
			end else begin
				runs[$] = runs[$] + 1;
			end
			lvl_q = signal_out_pin;
		end
	end
	// one symbol strobe, then scrambled lines and a pause
	task automatic send(input tbf_sym_kind_t k, input logic [8:0] d, input int gap);
		@(posedge aclk);
		rx_sym <= '{k, d};
		rx_sym_valid <= 1'b1;
		@(posedge aclk);
		rx_sym <= '{tbf_sym_kind_t'(~k), ~d};
		rx_sym_valid <= 1'b0;
		repeat (gap) @(posedge aclk);
	endtask
endmodule
`default_nettype wire

// ===== dv/testbench.sv
// testbench: registers, tuning outputs, receive framing, transmit line shape
// assumes package, framer, far-side model and checker compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench
	import tbf_pkg::*;
;
	localparam int DLY = 4;
	logic aclk = 1'b0, aresetn = 1'b0, carrier_tick = 1'b0, rec = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, hp_corner, rx_rate = 2'h0;
	tbf_tx_char_t tx_char = '0;
	tbf_rx_sym_t rx_sym;
	logic tx_valid = 1'b0, tx_ack, signal_out_pin, rx_sym_valid, rx_data_nine, rx_data_valid;
	logic fast_miller_filter, wide_pll, irq;
	logic [8:0] rx_data;
	logic [9:0] rx_last;
	int bad_count = 0, num_checks = 0, rx_cnt = 0, first_q[$], ex[$];
	tbf_framer #(.DELAY_FC(DLY)) i_tbf_framer (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.carrier_tick, .rx_rate, .tx_char, .tx_valid, .tx_ack, .signal_out_pin, .rx_sym, .rx_sym_valid, .rx_data,
		.rx_data_nine, .rx_data_valid, .hp_corner, .fast_miller_filter, .wide_pll, .irq);
	tbf_peer i_tbf_peer (.aclk, .carrier_tick, .signal_out_pin, .rec, .rx_sym, .rx_sym_valid);
	initial begin
		forever #20 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		carrier_tick <= ~carrier_tick;
		if (rx_data_valid) begin
			rx_cnt <= rx_cnt + 1;
			rx_last <= {rx_data_nine, rx_data};
		end
	end
	task automatic end_sim();
		if (bad_count == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && n < 100);
		chk("bresp", r, s_axi_bresp);
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = RESP_OKAY);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 100);
		chk("rresp", r, s_axi_rresp);
		chk("rdata", e, s_axi_rdata);
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rxf(input logic [7:0] cfg, input logic [7:0] tun, input logic [7:0] en, input logic sof,
			input logic [8:0] d, input tbf_sym_kind_t fin, input logic [7:0] st, input int cnt, input logic [9:0] e);
		wr(ADDR_TYPEB, cfg);
		wr(ADDR_TUNING, tun);
		wr(ADDR_IRQ_ENABLE, en);
		rx_cnt = 0;
		if (sof) i_tbf_peer.send(SYM_SOF, 9'h0, 0);
		i_tbf_peer.send(SYM_CHAR, d, 3);
		i_tbf_peer.send(fin, 9'h0, 0);
		repeat (4) @(posedge aclk);
		rd(ADDR_IRQ_STATUS, st);
		chk("irq", (st & en) != 0, irq);
		chk("rx count", cnt, rx_cnt);
		if (cnt > 0) chk("rx data", e, rx_last);
		wr(ADDR_IRQ_CLEAR, 32'h1f);
		rd(ADDR_IRQ_STATUS, 32'h0);
		chk("irq cleared", 0, irq);
	endtask
	function automatic void push(input logic l, input int n);
		if (n == 0) return;
		if (ex.size() > 0 && (ex.size() % 2 == 1) == l) ex[$] += n;
		else ex.push_back(n);
	endfunction
	task automatic t_tx(input logic [7:0] cfg, input logic adj, input logic [7:0] tun);
		logic [7:0] c[2];
		int lo, hi, n;
		c = '{8'h5a, 8'hc3};
		lo = cfg[4] ? 11 * ETU_FC - (adj ? ADJUST_FC : 0) : 10 * ETU_FC;
		hi = cfg[4] ? (adj ? 2 * ETU_FC + ADJUST_FC : 3 * ETU_FC) : 2 * ETU_FC;
		wr(ADDR_TYPEB, cfg);
		wr(ADDR_CTRL, adj);
		wr(ADDR_TUNING, tun);
		wr(ADDR_IRQ_ENABLE, 32'h8);
		ex.delete();
		push(1, 1);
		if (!cfg[3]) begin
			push(0, lo);
			push(1, hi);
		end
		for (int k = 0; k < 2; k++) begin
			push(0, ETU_FC);
			for (int b = 0; b < 8; b++) push(c[k][b], ETU_FC);
			if (!tun[4]) push(~^c[k], ETU_FC);
			push(1, ETU_FC + (k == 0 ? cfg[1:0] * ETU_FC : 0));
		end
		if (!cfg[2]) push(0, lo);
		push(1, 1);
		i_tbf_peer.runs.delete();
		do @(posedge aclk); while (!carrier_tick);
		tx_char <= '{c[0], 1'b0};
		tx_valid <= 1'b1;
		rec <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			n = 0;
			do begin
				@(posedge aclk);
				n++;
			end while (!tx_ack && n < 20000);
			tx_char <= '{c[1], 1'b1};
		end
		tx_valid <= 1'b0;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (!irq && n < 20000);
		chk("tx done irq", 1, irq);
		repeat (40) @(posedge aclk);
		rec <= 1'b0;
		@(posedge aclk);
		chk("run count", ex.size(), i_tbf_peer.runs.size());
		for (int i = 1; i < ex.size() - 1 && i < i_tbf_peer.runs.size(); i++) chk("run", ex[i], i_tbf_peer.runs[i]);
		first_q.push_back(i_tbf_peer.runs[0]);
		wr(ADDR_IRQ_CLEAR, 32'h1f);
	endtask
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(ADDR_TUNING, 32'h0);
		rd(ADDR_TYPEB, 32'h0);
		wr(ADDR_TUNING, 32'hffff_ffff);
		rd(ADDR_TUNING, 32'h7f);
		wr(ADDR_TYPEB, 32'hff);
		rd(ADDR_TYPEB, 32'hdf);
		wr(8'h90, 32'h1, RESP_SLVERR);
		rd(8'h90, 32'h0, RESP_SLVERR);
		rd(ADDR_IRQ_CLEAR, 32'h0);
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_TUNING, 32'h0);
			rx_rate <= 2'(i);
			repeat (3) @(posedge aclk);
			chk("auto corner", i, hp_corner);
			chk("filter off", 0, fast_miller_filter);
			chk("pll narrow", 0, wide_pll);
			wr(ADDR_TUNING, 32'h4c | i);
			rx_rate <= ~2'(i);
			repeat (3) @(posedge aclk);
			chk("manual corner", i, hp_corner);
			chk("filter on", 1, fast_miller_filter);
			chk("wide pll", 1, wide_pll);
		end
		rxf(8'h00, 8'h00, 8'h1f, 1, 9'h15a, SYM_EOF, 8'h01, 1, 10'h05a);
		rxf(8'h80, 8'h00, 8'h1f, 0, 9'h15a, SYM_EOF, 8'h10, 0, 10'h000);
		rxf(8'h00, 8'h00, 8'h00, 0, 9'h15a, SYM_EOF, 8'h01, 1, 10'h05a);
		rxf(8'h40, 8'h00, 8'h1f, 1, 9'h15a, SYM_END, 8'h02, 1, 10'h05a);
		rxf(8'h00, 8'h00, 8'h1f, 1, 9'h15a, SYM_END, 8'h01, 1, 10'h05a);
		rxf(8'h00, 8'h10, 8'h1f, 1, 9'h05a, SYM_EOF, 8'h01, 1, 10'h25a);
		rxf(8'h00, 8'h00, 8'h1f, 1, 9'h05a, SYM_EOF, 8'h05, 1, 10'h05a);
		t_tx(8'h03, 1'b0, 8'h00);
		t_tx(8'h11, 1'b1, 8'h30);
		t_tx(8'h12, 1'b0, 8'h00);
		t_tx(8'h0c, 1'b0, 8'h00);
		chk("output delay", first_q[0] + DLY, first_q[1]);
		end_sim();
	end
	initial begin
		repeat (100000) @(posedge aclk);
		bad_count++;
		end_sim();
	end
endmodule
bind tbf_framer tbf_monitor i_tbf_monitor (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .tx_valid, .tx_ack, .rx_sym,
	.rx_sym_valid, .rx_data, .rx_data_nine, .rx_data_valid);
`default_nettype wire
